/* File: bench/fdcfg_host.sv */
// host model: issues register reads and writes to the bank
// assumes core_clk from the bench; drives only at falling edges
`timescale 1ns/10ps
module fdcfg_host
  import fdcfg_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic [7:0] rdata,
  output fdcfg_acc_s      acc
);
  // idle bus at start
  initial acc = '0;

  // one write pulse; released lines scrambled, not left at last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    acc = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    acc = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  // one read pulse; data is registered, so taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    acc = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~acc.wdata};
    @(negedge core_clk);
    acc.rd = 1'b0;
    acc.addr = ~a;
    @(negedge core_clk);
    d = rdata;
  endtask : rd
endmodule : fdcfg_host

/* File: bench/tb_flash_driver_config_flags_regs.sv */
// bench for the config/flag bank, one task per scenario
// assumes bank and host model compiled first; inputs move at falling edge
`timescale 1ns/10ps
module tb_flash_driver_config_flags_regs
  import fdcfg_pkg::*;
;
  localparam logic [2:0] ID_DEV = 3'h3; // arbitrary value
  localparam logic [2:0] ID_REV = 3'h4; // arbitrary value
  logic       core_clk;    // 25 MHz
  logic       rst_b;       // async, active low
  logic       led_active;  // output stage busy
  logic [7:0] evt1;        // first flag events
  logic [4:0] evt2;        // second flag events
  fdcfg_acc_s acc;         // from host model
  fdcfg_cfg_s cfg;         // settings out
  logic [7:0] rdata;       // read data
  int         num_errors;  // mismatches seen
  int         checks_done; // comparisons made

  fdcfg_regs #(.DEV_ID(ID_DEV), .SIL_REV(ID_REV)) dut (.core_clk(core_clk), .rst_b(rst_b),
    .acc(acc), .led_active(led_active), .evt1_async(evt1), .evt2_async(evt2), .cfg(cfg),
    .rdata(rdata));
  fdcfg_host host (.core_clk(core_clk), .rdata(rdata), .acc(acc));

  // free running clock
  always #20 core_clk = ~core_clk;

  // compare and count
  task automatic chk(input string what, input logic [10:0] e, input logic [10:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk

  // read through the host and compare
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk("rdata", e, d);
  endtask : rdchk

  // hold events long enough for the synchronizer, then drop them
  task automatic pulse(input logic [7:0] e1, input logic [4:0] e2);
    evt1 = e1;
    evt2 = e2;
    repeat (4) @(negedge core_clk);
    evt1 = 8'h00;
    evt2 = 5'h00;
    repeat (4) @(negedge core_clk);
  endtask : pulse

  task automatic t_reset();
    rdchk(8'h07, 8'h09);
    rdchk(8'h08, 8'h1A);
    rdchk(8'h09, 8'h08);
    rdchk(8'h0A, 8'h00);
    rdchk(8'h0B, 8'h00);
    rdchk(8'h0C, {2'b00, ID_DEV, ID_REV});
    rdchk(8'h3C, 8'h00);
    chk("ramp_ms", 11'h001, cfg.ramp_ms);
    chk("timeout_ms", 11'h096, cfg.timeout_ms);
    $display("test reset done");
  endtask : t_reset

  task automatic t_boost();
    host.wr(8'h07, 8'h76);
    chk("sw_reset", 11'h000, cfg.sw_reset);
    chk("boost", 11'h006, {cfg.short_det_en, cfg.pass_only, cfg.freq_4mhz, cfg.ilim_high});
    rdchk(8'h07, 8'h06);
    host.wr(8'h0C, 8'hFF);
    rdchk(8'h0C, {2'b00, ID_DEV, ID_REV});
    $display("test boost done");
  endtask : t_boost

  task automatic t_timing();
    for (int c = 0; c < 16; c++)
    begin
      host.wr(8'h08, {1'b1, c[2:0], c[3:0]});
      @(negedge core_clk);
      chk("ramp_ms", (c[2:0] < 2) ? c[2:0] : 11'h001 << (c[2:0] + 3), cfg.ramp_ms);
      chk("timeout_ms", (c < 10) ? 10 * (c + 1) : 150 + 50 * (c - 10), cfg.timeout_ms);
    end
    rdchk(8'h08, 8'h7F);
    $display("test timing done");
  endtask : t_timing

  task automatic t_therm();
    host.wr(8'h09, 8'hFF);
    // applied polarity lags the register by one more edge
    @(negedge core_clk);
    chk("therm", 11'h0BF, {cfg.torch_act_low, cfg.pulldown_en, cfg.open_det_en,
      cfg.short_ntc_en, cfg.temp_thresh, cfg.pin_temp_sel});
    rdchk(8'h09, 8'h7F);
    led_active = 1'b1;
    host.wr(8'h09, 8'h08);
    // let the new register value reach the hold logic
    @(negedge core_clk);
    chk("pol held", 11'h001, cfg.torch_act_low);
    led_active = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("pol", 11'h001, {cfg.torch_act_low, cfg.pulldown_en});
    $display("test therm done");
  endtask : t_therm

  task automatic t_flags();
    host.wr(8'h07, 8'h01);
    pulse(8'hFF, 5'h1F);
    rdchk(8'h0A, 8'h8F);
    rdchk(8'h0A, 8'h00);
    rdchk(8'h0B, 8'h07);
    host.wr(8'h07, 8'h09);
    host.wr(8'h09, 8'h38);
    pulse(8'h70, 5'h18);
    rdchk(8'h0A, 8'h70);
    rdchk(8'h0B, 8'h18);
    $display("test flags done");
  endtask : t_flags

  task automatic t_soft();
    host.wr(8'h08, 8'h25);
    pulse(8'h01, 5'h01);
    host.wr(8'h07, 8'h80);
    chk("sw_reset", 11'h001, cfg.sw_reset);
    @(negedge core_clk);
    chk("sw_reset", 11'h000, cfg.sw_reset);
    rdchk(8'h07, 8'h09);
    rdchk(8'h08, 8'h1A);
    rdchk(8'h09, 8'h08);
    rdchk(8'h0A, 8'h00);
    $display("test soft reset done");
  endtask : t_soft

  // single ending point for pass, fail and hang
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // main sequence
  initial
  begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    led_active = 1'b0;
    evt1 = 8'h00;
    evt2 = 5'h00;
    num_errors = 0;
    checks_done = 0;
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    @(negedge core_clk);
    t_reset();
    t_boost();
    t_timing();
    t_therm();
    t_flags();
    t_soft();
    close_out();
  end

  // watchdog, well past the under two hundred cycles the tests need
  initial
  begin
    repeat (5000) @(negedge core_clk);
    num_errors++;
    close_out();
  end
endmodule : tb_flash_driver_config_flags_regs

/* File: include/fdcfg_params.svh */
// constants for the flash driver config/flag register bank
// assumes 8-bit internal register addresses and data
`ifndef FDCFG_PARAMS_SVH
`define FDCFG_PARAMS_SVH
// register addresses
`define FDCFG_ADR_BOOST   8'h07
`define FDCFG_ADR_TIMING  8'h08
`define FDCFG_ADR_THERM   8'h09
`define FDCFG_ADR_FLAG1   8'h0A
`define FDCFG_ADR_FLAG2   8'h0B
`define FDCFG_ADR_IDENT   8'h0C
// reset values
`define FDCFG_RST_BOOST   8'h09
`define FDCFG_RST_TIMING  8'h1A
`define FDCFG_RST_THERM   8'h08
`define FDCFG_RST_FLAG    8'h00
// writable bits, reserved and action bits excluded; FDCFG_MSK_FLAG2 keeps the five read-only flag2 bits
`define FDCFG_WMSK_BOOST  8'h0F
`define FDCFG_WMSK_TIMING 8'h7F
`define FDCFG_WMSK_THERM  8'h7F
`define FDCFG_MSK_FLAG2   8'h1F
// field positions
`define FDCFG_BIT_SWRST   7
`define FDCFG_BIT_SHORT   3
`define FDCFG_BIT_PASS    2
`define FDCFG_BIT_FREQ    1
`define FDCFG_BIT_ILIM    0
`define FDCFG_BIT_POL     6
`define FDCFG_BIT_OPEN    5
`define FDCFG_BIT_NSHORT  4
`define FDCFG_BIT_PINSEL  0
// timeout decode steps in ms
`define FDCFG_TO_FINE_MS  10
`define FDCFG_TO_CRS_MS   50
`define FDCFG_TO_SPLIT    4'hA
`endif

/* File: include/fdcfg_pkg.sv */
// types for the flash driver config/flag register bank
// assumes the params header is included by the users
package fdcfg_pkg;
  // one register access from the serial engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fdcfg_acc_s;
  // settings handed to the analog and current logic
  typedef struct packed {
    logic        sw_reset;
    logic        short_det_en;
    logic        pass_only;
    logic        freq_4mhz;
    logic        ilim_high;
    logic [2:0]  ramp_code;
    logic [10:0] ramp_ms;
    logic [3:0]  timeout_code;
    logic [8:0]  timeout_ms;
    logic        torch_act_low;
    logic        pulldown_en;
    logic        open_det_en;
    logic        short_ntc_en;
    logic [2:0]  temp_thresh;
    logic        pin_temp_sel;
  } fdcfg_cfg_s;
endpackage : fdcfg_pkg

/* File: logic/fdcfg_regs.sv */
// config, flag and identity registers of the flash driver
// assumes the serial engine gives one-cycle rd/wr pulses
// on core_clk; fault events are async levels from analog
`timescale 1ns/10ps
`include "fdcfg_params.svh"

// How it works
// [RQ1] writing one to bit 7 resets device
// [RQ2] bit 3 enables led pin short detection
// [RQ3] bit 2 selects pass-through-only boost mode
// [RQ4] bit 1 selects 4 MHz, else 2 MHz
// [RQ5] bit 0 selects 2.8 A, else 1.9 A
// [RQ6] bits 6:4 give torch ramp time
// [RQ7] bits 3:0 give flash timeout duration
// [RQ8] bit 6 sets torch polarity and pulldown
// [RQ9] host changes polarity only while disabled
// [RQ10] bit 5 enables open thermistor detection
// [RQ11] bit 4 enables shorted thermistor detection
// [RQ12] three-bit temperature threshold 0.2 to 0.9 V
// [RQ13] bit 0 assigns shared pin torch/thermistor
// [RQ14] first flag register bit layout
// [RQ15] second flag register bit layout
// [RQ16] identity register: part_identification and revision
// [RQ17] reserved zero; flags sticky until read
module fdcfg_regs
  import fdcfg_pkg::*;
#(
  parameter logic [2:0] DEV_ID  = 3'h5, // arbitrary value
  parameter logic [2:0] SIL_REV = 3'h1  // arbitrary value
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire fdcfg_acc_s acc,
  input  wire logic       led_active,
  input  wire logic [7:0] evt1_async,
  input  wire logic [4:0] evt2_async,
  output fdcfg_cfg_s      cfg,
  output logic [7:0]      rdata
);

  // timeout code to ms, fine then coarse steps
  function automatic logic [8:0] to_ms(input logic [3:0] c);
    logic [8:0] r;
    r = 9'h000;
    if (c < `FDCFG_TO_SPLIT)
      r = 9'(({5'h00, c} + 9'h001) * `FDCFG_TO_FINE_MS);
    else
      r = 9'(({5'h00, c} - 9'h007) * `FDCFG_TO_CRS_MS);
    return r;
  endfunction : to_ms

  // ramp code to ms, zero means no ramp
  function automatic logic [10:0] ramp_to_ms(input logic [2:0] c);
    logic [10:0] r;
    r = 11'h000;
    if (c == 3'h1)
      r = 11'h001;
    else if (c != 3'h0)
      // code 2 is 32 ms, each step doubles up to 1024 ms
      r = 11'(11'h008 << c);
    return r;
  endfunction : ramp_to_ms

  // register storage
  logic [7:0]  boost_ff;     // boost converter config
  logic [7:0]  timing_ff;    // ramp and timeout
  logic [7:0]  therm_ff;     // thermistor / pin config
  logic [7:0]  flag1_ff;     // sticky flags, first
  logic [7:0]  flag2_ff;     // sticky flags, second
  logic        pol_ff;       // polarity as applied
  // own flop so the pulldown control has no gate after it
  logic        pd_ff;        // pulldown as applied
  logic        swrst_ff;     // soft reset pulse out
  logic [8:0]  to_ms_ff;     // decoded timeout
  logic [10:0] ramp_ms_ff;   // decoded ramp
  logic [7:0]  rdata_ff;     // read return
  // event synchronisers
  logic [7:0]  e1_s1_ff;
  logic [7:0]  e1_s2_ff;
  logic [4:0]  e2_s1_ff;
  logic [4:0]  e2_s2_ff;

  // address decode
  wire hit_boost  = acc.addr == `FDCFG_ADR_BOOST;
  wire hit_timing = acc.addr == `FDCFG_ADR_TIMING;
  wire hit_therm  = acc.addr == `FDCFG_ADR_THERM;
  wire hit_flag1  = acc.addr == `FDCFG_ADR_FLAG1;
  wire hit_flag2  = acc.addr == `FDCFG_ADR_FLAG2;
  wire hit_ident  = acc.addr == `FDCFG_ADR_IDENT;

  // [RQ1] soft reset request
  wire swrst_req = acc.wr && hit_boost
                   && acc.wdata[`FDCFG_BIT_SWRST];

  // write strobes; reserved bits dropped by masks
  wire wr_boost  = acc.wr && hit_boost;
  wire wr_timing = acc.wr && hit_timing;
  wire wr_therm  = acc.wr && hit_therm;

  // [RQ2] led/output short gating
  wire [7:0] gate1 = {1'b1,
                      {3{boost_ff[`FDCFG_BIT_SHORT]}},
                      4'hF};
  // [RQ10] open thermistor gating
  wire g_open = therm_ff[`FDCFG_BIT_OPEN];
  // [RQ11] shorted thermistor gating
  wire g_shrt = therm_ff[`FDCFG_BIT_NSHORT];
  wire [4:0] gate2 = {g_shrt, g_open, 3'h7};

  // [RQ17] set beats clear-on-read
  wire [7:0] clr1 = {8{acc.rd && hit_flag1}};
  wire [4:0] clr2 = {5{acc.rd && hit_flag2}};
  wire [7:0] nxt_flag1 = (flag1_ff & ~clr1)
                         | (e1_s2_ff & gate1);
  wire [7:0] nxt_flag2 = ((flag2_ff & ~{3'h0, clr2})
                         | {3'h0, e2_s2_ff & gate2})
                         & `FDCFG_MSK_FLAG2;

  // [RQ16] identity word, top bits reserved
  wire [7:0] ident = {2'b00, DEV_ID, SIL_REV};

  // read mux; unmapped reads return zero
  wire [7:0] nxt_rdata =
      hit_boost  ? (boost_ff & `FDCFG_WMSK_BOOST)   :
      hit_timing ? (timing_ff & `FDCFG_WMSK_TIMING) :
      hit_therm  ? (therm_ff & `FDCFG_WMSK_THERM)   :
      hit_flag1  ? flag1_ff                         :
      hit_flag2  ? flag2_ff                         :
      hit_ident  ? ident                            :
      8'h00;

  // [RQ9] polarity frozen while driving leds
  wire nxt_pol = led_active ? pol_ff
                 : therm_ff[`FDCFG_BIT_POL];

  // two-stage sync of analog event levels
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      e1_s1_ff <= 8'h00;
      e1_s2_ff <= 8'h00;
      e2_s1_ff <= 5'h00;
      e2_s2_ff <= 5'h00;
    end
    else
    begin
      e1_s1_ff <= evt1_async;
      e1_s2_ff <= e1_s1_ff;
      e2_s1_ff <= evt2_async;
      e2_s2_ff <= e2_s1_ff;
    end
  end

  // config registers; soft reset restores defaults
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      boost_ff  <= `FDCFG_RST_BOOST;
      timing_ff <= `FDCFG_RST_TIMING;
      therm_ff  <= `FDCFG_RST_THERM;
    end
    // [RQ1] defaults on soft reset
    else if (swrst_req)
    begin
      boost_ff  <= `FDCFG_RST_BOOST;
      timing_ff <= `FDCFG_RST_TIMING;
      therm_ff  <= `FDCFG_RST_THERM;
    end
    else
    begin
      // [RQ3] boost field write
      if (wr_boost)
        boost_ff <= acc.wdata & `FDCFG_WMSK_BOOST;
      // [RQ7] timing field write
      if (wr_timing)
        timing_ff <= acc.wdata & `FDCFG_WMSK_TIMING;
      // [RQ12] thermistor field write
      if (wr_therm)
        therm_ff <= acc.wdata & `FDCFG_WMSK_THERM;
    end
  end

  // sticky flags, polarity, decodes, read data
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flag1_ff   <= `FDCFG_RST_FLAG;
      flag2_ff   <= `FDCFG_RST_FLAG;
      pol_ff     <= 1'b0;
      pd_ff      <= 1'b1;
      swrst_ff   <= 1'b0;
      to_ms_ff   <= 9'h000;
      ramp_ms_ff <= 11'h000;
      rdata_ff   <= 8'h00;
    end
    else
    begin
      // [RQ14] flags cleared by soft reset too
      flag1_ff   <= swrst_req ? `FDCFG_RST_FLAG : nxt_flag1;
      // [RQ15] reserved bits stay zero
      flag2_ff   <= swrst_req ? `FDCFG_RST_FLAG : nxt_flag2;
      pol_ff     <= nxt_pol;
      // [RQ8] pulldown only while active high
      pd_ff      <= ~nxt_pol;
      swrst_ff   <= swrst_req;
      // [RQ7] timeout decode
      to_ms_ff   <= to_ms(timing_ff[3:0]);
      // [RQ6] ramp decode
      ramp_ms_ff <= ramp_to_ms(timing_ff[6:4]);
      if (acc.rd)
        rdata_ff <= nxt_rdata;
    end
  end

  // outputs: every field is a flip-flop
  assign rdata             = rdata_ff;
  assign cfg.sw_reset      = swrst_ff;
  assign cfg.short_det_en  = boost_ff[`FDCFG_BIT_SHORT];
  // [RQ3] pass-through-only select
  assign cfg.pass_only     = boost_ff[`FDCFG_BIT_PASS];
  // [RQ4] switching frequency select
  assign cfg.freq_4mhz     = boost_ff[`FDCFG_BIT_FREQ];
  // [RQ5] peak current limit select
  assign cfg.ilim_high     = boost_ff[`FDCFG_BIT_ILIM];
  assign cfg.ramp_code     = timing_ff[6:4];
  assign cfg.ramp_ms       = ramp_ms_ff;
  assign cfg.timeout_code  = timing_ff[3:0];
  assign cfg.timeout_ms    = to_ms_ff;
  // [RQ8] polarity and pulldown, opposite senses
  assign cfg.torch_act_low = pol_ff;
  assign cfg.pulldown_en   = pd_ff;
  assign cfg.open_det_en   = g_open;
  assign cfg.short_ntc_en  = g_shrt;
  // [RQ12] threshold code, 0.2 V plus 0.1 V steps
  assign cfg.temp_thresh   = therm_ff[3:1];
  // [RQ13] shared pin function
  assign cfg.pin_temp_sel  = therm_ff[`FDCFG_BIT_PINSEL];

  // checks on the block's own behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // a boost write without the reset bit
  sequence boost_wr_s;
    acc.wr && hit_boost && !acc.wdata[7];
  endsequence

  // a write of the timing register
  sequence timing_wr_s;
    acc.wr && hit_timing;
  endsequence

  // soft reset pulse and default restore
  soft_reset_a: assert property ( // RQ1
    swrst_req |=> swrst_ff && boost_ff == `FDCFG_RST_BOOST
      && timing_ff == `FDCFG_RST_TIMING && therm_ff == `FDCFG_RST_THERM
      && flag1_ff == `FDCFG_RST_FLAG)
    else $error("soft reset not applied");

  // reset pulse only after a reset write
  sw_pulse_a: assert property ( // RQ1
    !swrst_req |=> !cfg.sw_reset)
    else $error("stray soft reset pulse");

  // led short flag bit 5 only rises when enabled
  short_gate_a: assert property ( // RQ2
    $rose(flag1_ff[5]) |-> $past(boost_ff[3]))
    else $error("led short flag while disabled");

  // pass mode follows a boost write
  pass_mode_a: assert property ( // RQ3
    boost_wr_s ##1 1'b1 |-> cfg.pass_only
      == $past(acc.wdata[2]))
    else $error("pass mode not written");

  // frequency follows a boost write
  freq_sel_a: assert property ( // RQ4
    boost_wr_s |=> cfg.freq_4mhz == $past(acc.wdata[1]))
    else $error("frequency select wrong");

  // current limit follows a boost write
  ilim_sel_a: assert property ( // RQ5
    boost_wr_s |=> cfg.ilim_high == $past(acc.wdata[0]))
    else $error("current limit wrong");

  // ramp decode lands two cycles later
  ramp_dec_a: assert property ( // RQ6
    timing_wr_s ##1 !acc.wr [*1] |=> cfg.ramp_ms
      == ramp_to_ms($past(acc.wdata[6:4], 2)))
    else $error("ramp decode wrong");

  // timeout decode lands two cycles later
  timeout_dec_a: assert property ( // RQ7
    timing_wr_s ##1 !acc.wr [*1] |=> cfg.timeout_ms
      == to_ms($past(acc.wdata[3:0], 2)))
    else $error("timeout decode wrong");

  // polarity held while leds are driven
  pol_hold_a: assert property ( // RQ8
    led_active && $past(led_active) |-> $stable(pol_ff)
      && cfg.pulldown_en != cfg.torch_act_low)
    else $error("polarity moved while active");

  // open thermistor flag needs its enable
  ntc_open_a: assert property ( // RQ10
    $rose(flag2_ff[3]) |-> $past(g_open))
    else $error("open flag while disabled");

  // shorted thermistor flag needs its enable
  ntc_short_a: assert property ( // RQ11
    $rose(flag2_ff[4]) |-> $past(g_shrt))
    else $error("short flag while disabled");

  // second flag reserved bits read zero
  flag2_rsvd_a: assert property ( // RQ15
    acc.rd && hit_flag2 |=> rdata[7:5] == 3'h0)
    else $error("reserved flag bits set");

  // identity read returns id and revision
  ident_rd_a: assert property ( // RQ16
    acc.rd && hit_ident |=> rdata == {2'b00, DEV_ID, SIL_REV})
    else $error("identity read wrong");

  // first flag bit 0 stays set until read or soft reset
  flag_sticky_a: assert property ( // RQ17
    flag1_ff[0] && !(acc.rd && hit_flag1) && !swrst_req
      |=> flag1_ff[0])
    else $error("flag dropped without read");

  // boost reserved and reset bits read zero
  boost_rsvd_a: assert property ( // RQ17
    acc.rd && hit_boost |=> rdata[7:4] == 4'h0)
    else $error("boost reserved bits set");

  // pulldown always opposite to polarity
  pull_sense_a: assert property ( // RQ8
    cfg.pulldown_en != cfg.torch_act_low)
    else $error("pulldown sense wrong");

  // longest ramp code gives 1024 ms, fixed value
  ramp_top_a: assert property ( // RQ6
    acc.wr && hit_timing && acc.wdata[6:4] == 3'h7 ##1 !acc.wr
      |=> cfg.ramp_ms == 11'h400)
    else $error("longest ramp wrong");

endmodule : fdcfg_regs
